// ===== src/slave_comm_watchdog.sv
/*
 * Slave supervision: communication monitor and watchdog, nibble
 * toggle watchdog, extension code protection and overload latch.
 * Assumes request strobes are one-cycle pulses from the protocol
 * engine on clk_sys_i; parameter_port_zero and overload come from
 * pins and are synchronised here.
 */
module slave_comm_watchdog
    import slave_wd_pkg::*;
#(
    parameter int unsigned MON_LIMIT = MON_CYCLES,
    parameter int unsigned TOG_LIMIT = TOG_CYCLES,
    parameter int unsigned OVL_LIMIT = OVL_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [4:0] slave_address_i,
    input wire logic data_exchange_i,
    input wire logic write_parameter_i,
    input wire logic delete_address_i,
    input wire logic nibble_toggle_bit_i,
    input wire logic watchdog_enable_i,
    input wire logic port_gated_watchdog_enable_i,
    input wire logic parameter_port_zero_i,
    input wire logic [3:0] slave_profile_code_i,
    input wire logic extended_quad_io_select_i,
    input wire logic extended_address_mode_i,
    input wire logic ext_code_protect_flag_i,
    input wire logic [3:0] user_ext_code_i,
    input wire logic [3:0] factory_ext_code_i,
    input wire logic read_ext_code_i,
    input wire logic write_ext_code_i,
    input wire logic [3:0] write_ext_data_i,
    input wire logic supply_overload_i,
    output logic red_status_led_o,
    output logic watchdog_reset_o,
    output logic exchange_disable_o,
    output logic monitor_active_o,
    output logic toggle_active_o,
    output logic [3:0] ext_code_resp_o,
    output logic ext_code_resp_valid_o,
    output logic ext_code_nv_write_o,
    output logic [3:0] ext_code_nv_data_o,
    output logic shutdown_o
);
    // =========================================================
    // pin synchronisers
    logic p0_meta_q, p0_q, ovl_meta_q, ovl_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            p0_meta_q <= 1'b0;
            p0_q <= 1'b0;
            ovl_meta_q <= 1'b0;
            ovl_q <= 1'b0;
        end else begin
            p0_meta_q <= parameter_port_zero_i;
            p0_q <= p0_meta_q;
            ovl_meta_q <= supply_overload_i;
            ovl_q <= ovl_meta_q;
        end
    end

    // =========================================================
    // common terms
    logic addr_ok, wd_mode, quad_armed, exch_req, data_out_ev;
    logic wd_reset_req, mon_expired, tog_expired, tog_edge;
    logic mon_active_q, tog_active_q, nts_q, led_q, tog_bit_q;
    logic [2:0] rst_cnt_q;
    logic blocked_q;

    assign addr_ok = slave_address_i != 5'h00;
    assign wd_mode = watchdog_enable_i
        || (port_gated_watchdog_enable_i && p0_q);
    assign quad_armed = (slave_profile_code_i == QUAD_IO_PROFILE)
        && extended_quad_io_select_i && wd_mode;
    assign exch_req = data_exchange_i || write_parameter_i;
    // blocked exchanges carry no output event
    assign data_out_ev = data_exchange_i && !blocked_q;
    assign tog_edge = data_out_ev && (nibble_toggle_bit_i != tog_bit_q);

    // =========================================================
    // communication monitor
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mon_active_q <= 1'b0;
        end else if (delete_address_i || wd_reset_req) begin
            mon_active_q <= 1'b0;
        end else if (write_parameter_i && addr_ok) begin
            mon_active_q <= 1'b1;
        end
    end

    expiry_timer #(
        .LIMIT(MON_LIMIT)
    ) u_mon_timer (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .run_i(mon_active_q && !nts_q),
        .restart_i(exch_req),
        .expired_o(mon_expired)
    );

    // no-exchange status; request wins over expiry
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nts_q <= 1'b0;
        end else if (!mon_active_q || exch_req || delete_address_i) begin
            nts_q <= 1'b0;
        end else if (mon_expired) begin
            nts_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_q <= 1'b0;
        end else begin
            led_q <= nts_q;
        end
    end

    // =========================================================
    // nibble toggle watchdog
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tog_active_q <= 1'b0;
        end else if (delete_address_i || wd_reset_req) begin
            tog_active_q <= 1'b0;
        end else if (data_out_ev && addr_ok) begin
            tog_active_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tog_bit_q <= 1'b0;
        end else if (data_out_ev) begin
            tog_bit_q <= nibble_toggle_bit_i;
        end
    end

    expiry_timer #(
        .LIMIT(TOG_LIMIT)
    ) u_tog_timer (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .run_i(tog_active_q && quad_armed),
        .restart_i(tog_edge || (data_out_ev && !tog_active_q)),
        .expired_o(tog_expired)
    );

    // =========================================================
    // unconditioned reset sequence
    assign wd_reset_req = (mon_expired && wd_mode && !nts_q)
        || tog_expired;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_cnt_q <= 3'h0;
        end else if (wd_reset_req) begin
            rst_cnt_q <= 3'(RESET_PULSE_CYCLES);
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end
    end

    // exchange stays blocked until a fresh parameter write
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            blocked_q <= 1'b0;
        end else if (wd_reset_req) begin
            blocked_q <= 1'b1;
        end else if (write_parameter_i) begin
            blocked_q <= 1'b0;
        end
    end

    // =========================================================
    // extension code protection
    logic [3:0] read_word, prot_mask;
    logic write_ok;
    logic [3:0] resp_q, nv_data_q;
    logic resp_v_q, nv_wr_q;

    always_comb begin
        prot_mask = 4'hf;
        if (extended_address_mode_i) begin
            prot_mask[SELECTOR_BIT] = 1'b0;
        end
        if (ext_code_protect_flag_i) begin
            read_word = (factory_ext_code_i & prot_mask)
                | (user_ext_code_i & ~prot_mask);
            write_ok = ((write_ext_data_i ^ factory_ext_code_i)
                & prot_mask) == 4'h0;
        end else begin
            read_word = user_ext_code_i;
            write_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resp_q <= 4'h0;
            resp_v_q <= 1'b0;
        end else if (read_ext_code_i) begin
            resp_q <= read_word;
            resp_v_q <= 1'b1;
        end else if (write_ext_code_i && write_ok) begin
            resp_q <= write_ext_data_i;
            resp_v_q <= 1'b1;
        end else begin
            resp_v_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nv_wr_q <= 1'b0;
            nv_data_q <= 4'h0;
        end else begin
            nv_wr_q <= write_ext_code_i && write_ok
                && !read_ext_code_i;
            if (write_ext_code_i && write_ok) begin
                nv_data_q <= write_ext_data_i;
            end
        end
    end

    // =========================================================
    // overload shutdown latch
    logic [CNT_W-1:0] ovl_cnt_q;
    logic shut_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ovl_cnt_q <= '0;
        end else if (!ovl_q) begin
            ovl_cnt_q <= '0;
        end else if (ovl_cnt_q != CNT_W'(OVL_LIMIT)) begin
            ovl_cnt_q <= ovl_cnt_q + CNT_W'(1);
        end
    end

    // released only by power-on reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shut_q <= 1'b0;
        end else if (ovl_cnt_q == CNT_W'(OVL_LIMIT)) begin
            shut_q <= 1'b1;
        end
    end

    // =========================================================
    // outputs
    assign red_status_led_o = led_q;
    assign watchdog_reset_o = rst_cnt_q != 3'h0;
    assign exchange_disable_o = blocked_q;
    assign monitor_active_o = mon_active_q;
    assign toggle_active_o = tog_active_q;
    assign ext_code_resp_o = resp_q;
    assign ext_code_resp_valid_o = resp_v_q;
    assign ext_code_nv_write_o = nv_wr_q;
    assign ext_code_nv_data_o = nv_data_q;
    assign shutdown_o = shut_q;

    // =========================================================
    // checks
    led_follows_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) nts_q |=> red_status_led_o)
        else $error("led not on after no-exchange status");
    req_clears_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) exch_req |=> !nts_q ##1 !red_status_led_o)
        else $error("request did not clear status");
    mon_start_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        $rose(mon_active_q) |-> $past(write_parameter_i) && $past(addr_ok))
        else $error("monitor started without parameter write");
    mon_stop_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) delete_address_i |=> !monitor_active_o)
        else $error("monitor active after address delete");
    wd_reset_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) wd_reset_req |=>
        watchdog_reset_o [*4] ##1 !watchdog_reset_o)
        else $error("reset pulse length wrong");
    block_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        exchange_disable_o && !write_parameter_i && !wd_reset_req
        |=> exchange_disable_o)
        else $error("exchange unblocked without parameter write");
    tog_start_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        $rose(tog_active_q) |-> $past(data_out_ev) && $past(addr_ok))
        else $error("toggle watchdog started without output event");
    tog_stop_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) delete_address_i |=> !toggle_active_o)
        else $error("toggle watchdog active after delete");
    drop_write_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        write_ext_code_i && !read_ext_code_i && !write_ok
        |=> !ext_code_nv_write_o && !ext_code_resp_valid_o)
        else $error("mismatched protected write not dropped");
    open_write_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        write_ext_code_i && !read_ext_code_i && !ext_code_protect_flag_i
        |=> ext_code_nv_write_o && ext_code_resp_valid_o)
        else $error("unprotected write not answered");
    shut_latch_a: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) shutdown_o |=> shutdown_o)
        else $error("shutdown released");
endmodule : slave_comm_watchdog

// ===== src/slave_wd_pkg.sv
/*
 * Constants for the slave communication watchdog block.
 * Assumes a 20 MHz system clock; times are held in microseconds.
 */
package slave_wd_pkg;
    // =========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MON_TIMEOUT_US = 40960;
    localparam int unsigned MON_TOL_PCT = 5;
    localparam int unsigned TOG_TIMEOUT_US = 327000;
    localparam int unsigned TOG_TOL_US = 16000;
    localparam int unsigned OVL_LIMIT_US = 2000000;
    // expiry placed mid-tolerance window
    localparam int unsigned MON_CYCLES =
        (MON_TIMEOUT_US * 1000 / CLK_PERIOD_NS) * (200 + MON_TOL_PCT) / 200;
    localparam int unsigned TOG_CYCLES =
        (TOG_TIMEOUT_US + TOG_TOL_US / 2) * 1000 / CLK_PERIOD_NS;
    localparam int unsigned OVL_CYCLES =
        OVL_LIMIT_US * (1000 / CLK_PERIOD_NS);
    // =========================================================
    // codes and field positions
    localparam logic [3:0] QUAD_IO_PROFILE = 4'ha;
    localparam int unsigned SELECTOR_BIT = 3;
    localparam int unsigned RESET_PULSE_CYCLES = 4;
    localparam int unsigned CNT_W = 26;
endpackage : slave_wd_pkg

// ===== src/expiry_timer.sv
/*
 * Restartable cycle counter with a one-cycle expiry pulse.
 * Assumes a single clock domain and an active-low async reset.
 */
module expiry_timer
    import slave_wd_pkg::*;
#(
    parameter int unsigned LIMIT = 1000
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic restart_i,
    output logic expired_o
);
    logic [CNT_W-1:0] count_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
        end else if (!run_i || restart_i) begin
            count_q <= '0;
        end else if (count_q != CNT_W'(LIMIT)) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    // pulse once as the count lands on the limit
    assign expired_o = run_i && !restart_i
        && (count_q == CNT_W'(LIMIT - 1));
endmodule : expiry_timer

// ===== tb/field_master_model.sv
/*
 * Bus master model: issues request strobes to the slave watchdog.
 * Assumes one clock; strobes change 2 ns after the rising edge.
 */
module field_master_model (
    input wire logic clk_sys_i,
    input wire logic [3:0] ext_code_resp_i,
    output logic data_exchange_o,
    output logic write_parameter_o,
    output logic delete_address_o,
    output logic nibble_toggle_bit_o,
    output logic read_ext_code_o,
    output logic write_ext_code_o,
    output logic [3:0] write_ext_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] rd_word;
    initial begin
        data_exchange_o = 1'b0;
        write_parameter_o = 1'b0;
        delete_address_o = 1'b0;
        nibble_toggle_bit_o = 1'b0;
        read_ext_code_o = 1'b0;
        write_ext_code_o = 1'b0;
        write_ext_data_o = 4'h0;
    end
    // =========================================================
    // one-cycle strobe; returns just after the taking edge
    task automatic strobe(input int sel);
        @(posedge clk_sys_i);
        #2;
        case (sel)
            0: data_exchange_o = 1'b1;
            1: write_parameter_o = 1'b1;
            2: delete_address_o = 1'b1;
            3: read_ext_code_o = 1'b1;
            default: write_ext_code_o = 1'b1;
        endcase
        @(posedge clk_sys_i);
        #2;
        data_exchange_o = 1'b0;
        write_parameter_o = 1'b0;
        delete_address_o = 1'b0;
        read_ext_code_o = 1'b0;
        write_ext_code_o = 1'b0;
    endtask : strobe
    task automatic exchange(input logic nib);
        nibble_toggle_bit_o = nib;
        strobe(0);
    endtask : exchange
    task automatic write_code(input logic [3:0] d);
        write_ext_data_o = d;
        strobe(4);
    endtask : write_code
    // read, change only the selector, write back
    task automatic flip_selector();
        strobe(3);
        rd_word = ext_code_resp_i;
        write_code({~rd_word[3], rd_word[2:0]});
    endtask : flip_selector
endmodule : field_master_model

// ===== tb/slave_comm_watchdog_tb_top.sv
/*
 * Self-checking bench for the slave watchdog block.
 * Assumes shortened limits; inputs change 2 ns after the edge.
 */
module slave_comm_watchdog_tb_top
    import slave_wd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned MON = 50;
    localparam int unsigned TOG = 80;
    localparam int unsigned OVL = 30;
    logic clk_sys_i = 1'b0;
    logic rst_b_i, wd_en, gated, port0, quad, extm, prot, ovl;
    logic [4:0] addr;
    logic [3:0] profile, user, fact;
    logic dx, wp, da, nb, rd, wr, led, wdr, exd, mon, tog, rv, nvw, shd;
    logic [3:0] wdat, resp, nvd;
    int num_errors = 0;
    int total_checks = 0;
    int hi;
    int hi_cnt = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    // reset cycles seen at every edge, strobe cycles included
    always @(posedge clk_sys_i) begin
        if (wdr === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    slave_comm_watchdog #(.MON_LIMIT(MON), .TOG_LIMIT(TOG),
        .OVL_LIMIT(OVL)) slave_comm_watchdog_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .slave_address_i(addr), .data_exchange_i(dx),
        .write_parameter_i(wp), .delete_address_i(da),
        .nibble_toggle_bit_i(nb), .watchdog_enable_i(wd_en),
        .port_gated_watchdog_enable_i(gated),
        .parameter_port_zero_i(port0), .slave_profile_code_i(profile),
        .extended_quad_io_select_i(quad), .extended_address_mode_i(extm),
        .ext_code_protect_flag_i(prot), .user_ext_code_i(user),
        .factory_ext_code_i(fact), .read_ext_code_i(rd),
        .write_ext_code_i(wr), .write_ext_data_i(wdat),
        .supply_overload_i(ovl), .red_status_led_o(led),
        .watchdog_reset_o(wdr), .exchange_disable_o(exd),
        .monitor_active_o(mon), .toggle_active_o(tog),
        .ext_code_resp_o(resp), .ext_code_resp_valid_o(rv),
        .ext_code_nv_write_o(nvw), .ext_code_nv_data_o(nvd),
        .shutdown_o(shd));
    field_master_model field_master_model_i (
        .clk_sys_i(clk_sys_i), .ext_code_resp_i(resp),
        .data_exchange_o(dx), .write_parameter_o(wp),
        .delete_address_o(da), .nibble_toggle_bit_o(nb),
        .read_ext_code_o(rd), .write_ext_code_o(wr),
        .write_ext_data_o(wdat));
    // =========================================================
    // checking and pacing
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic chk_bit(input string s, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", s, e, g);
        end
    endtask : chk_bit
    task automatic chk_nib(input string s, input logic [3:0] e,
        input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk_nib
    task automatic chk_cnt(input string s, input int e, input int g);
        total_checks++;
        if (g != e) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", s, e, g);
        end
    endtask : chk_cnt
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask : idle
    // counts cycles of watchdog reset over a fixed span
    task automatic watch(input int n, output int h);
        int h0;
        h0 = hi_cnt;
        idle(n);
        h = hi_cnt - h0;
    endtask : watch
    task automatic run_expiry(input logic e, g, p, x);
        wd_en = e;
        gated = g;
        port0 = p;
        idle(3);
        field_master_model_i.strobe(1);
        chk_bit("monitor on", 1'b1, mon);
        idle(MON - 5);
        chk_bit("led early", 1'b0, led);
        watch(15, hi);
        chk_cnt("reset cycles", x ? 4 : 0, hi);
        chk_bit("disable", x, exd);
        if (x) begin
            field_master_model_i.exchange(1'b0);
            chk_bit("blocked", 1'b1, exd);
            field_master_model_i.strobe(1);
            chk_bit("unblocked", 1'b0, exd);
        end else begin
            chk_bit("led on", 1'b1, led);
            field_master_model_i.exchange(1'b0);
            idle(2);
            chk_bit("led off", 1'b0, led);
        end
        field_master_model_i.strobe(2);
        idle(1);
        chk_bit("monitor off", 1'b0, mon);
    endtask : run_expiry
    task automatic tog_run(input logic alt, input int n, output int s);
        int h0;
        h0 = hi_cnt;
        for (int i = 0; i < n; i++) begin
            field_master_model_i.exchange(alt ? i[0] : 1'b1);
            idle(18);
        end
        s = hi_cnt - h0;
    endtask : tog_run
    // =========================================================
    // run limit
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        chk_bit("run end", 1'b1, 1'b0);
        test_done();
    end
    // =========================================================
    // main sequence
    initial begin
        int s;
        rst_b_i = 1'b0;
        {wd_en, gated, port0, quad, extm, prot, ovl} = 7'h00;
        addr = 5'h05;
        profile = 4'h0;
        user = 4'h6;
        fact = 4'h9;
        repeat (5) @(posedge clk_sys_i);
        #2;
        rst_b_i = 1'b1;
        chk_bit("reset led", 1'b0, led);
        chk_bit("reset shutdown", 1'b0, shd);
        addr = 5'h00;
        field_master_model_i.strobe(1);
        idle(1);
        chk_bit("address zero", 1'b0, mon);
        addr = 5'h05;
        run_expiry(1'b0, 1'b0, 1'b1, 1'b0);
        run_expiry(1'b1, 1'b0, 1'b0, 1'b1);
        run_expiry(1'b0, 1'b1, 1'b1, 1'b1);
        run_expiry(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test monitor ended");
        wd_en = 1'b1;
        profile = QUAD_IO_PROFILE;
        quad = 1'b1;
        field_master_model_i.strobe(1);
        tog_run(1'b1, 10, s);
        chk_cnt("toggling", 0, s);
        chk_bit("toggle on", 1'b1, tog);
        tog_run(1'b0, 8, s);
        chk_cnt("stuck bit", 4, s);
        profile = 4'h5;
        field_master_model_i.strobe(1);
        tog_run(1'b0, 8, s);
        chk_cnt("unarmed", 0, s);
        field_master_model_i.strobe(2);
        idle(1);
        chk_bit("toggle off", 1'b0, tog);
        wd_en = 1'b0;
        $display("test toggle ended");
        field_master_model_i.strobe(3);
        chk_bit("read valid", 1'b1, rv);
        chk_nib("read user", 4'h6, resp);
        field_master_model_i.write_code(4'h3);
        chk_nib("write open", 4'h3, nvd);
        prot = 1'b1;
        field_master_model_i.strobe(3);
        chk_nib("read factory", 4'h9, resp);
        field_master_model_i.write_code(4'h3);
        chk_bit("drop valid", 1'b0, rv);
        chk_bit("drop write", 1'b0, nvw);
        field_master_model_i.write_code(4'h9);
        chk_bit("match write", 1'b1, nvw);
        extm = 1'b1;
        field_master_model_i.strobe(3);
        chk_nib("read selector", 4'h1, resp);
        field_master_model_i.flip_selector();
        chk_bit("flip write", 1'b1, nvw);
        chk_nib("flip data", 4'h9, nvd);
        user = 4'hc;
        fact = 4'h5;
        field_master_model_i.strobe(3);
        chk_nib("read mixed", 4'hd, resp);
        prot = 1'b0;
        field_master_model_i.strobe(3);
        chk_nib("read open", 4'hc, resp);
        $display("test ext code ended");
        field_master_model_i.strobe(1);
        ovl = 1'b1;
        idle(OVL - 10);
        ovl = 1'b0;
        idle(4);
        chk_bit("short overload", 1'b0, shd);
        ovl = 1'b1;
        idle(OVL + 8);
        ovl = 1'b0;
        idle(4);
        chk_bit("shutdown held", 1'b1, shd);
        chk_bit("monitor held", 1'b1, mon);
        rst_b_i = 1'b0;
        idle(2);
        chk_bit("reset monitor", 1'b0, mon);
        chk_bit("power cycle", 1'b0, shd);
        rst_b_i = 1'b1;
        idle(2);
        chk_bit("after reset", 1'b0, shd);
        chk_bit("reset led", 1'b0, led);
        $display("test overload ended");
        test_done();
    end
endmodule : slave_comm_watchdog_tb_top
